// File: verilog/ddp_params.svh
// Named constants for the DDR2 pin command and data interface.
// Assumes inclusion by bare name from the package and the design.
`ifndef DDP_PARAMS_SVH
`define DDP_PARAMS_SVH

// ****************************************************************
// Command codes on {row, column, write strobe}
// ****************************************************************
`define DDP_CODE_MODE_SET  3'h0
`define DDP_CODE_REFRESH   3'h1
`define DDP_CODE_PRECHARGE 3'h2
`define DDP_CODE_ACTIVE    3'h3
`define DDP_CODE_WRITE     3'h4
`define DDP_CODE_READ      3'h5
`define DDP_CODE_TERMINATE 3'h6
`define DDP_CODE_NOP       3'h7

// ****************************************************************
// Mode set fields and reset values
// ****************************************************************
`define DDP_EXT_MODE_ONE_BANK 3'h1
`define DDP_DIFF_STROBE_BIT   10
`define DDP_RST_DIFF_MODE     1'h0
`define DDP_RST_CMD_BANK      3'h0
`define DDP_RST_WORD          16'h0000
`define DDP_RST_LANES         2'h0

`endif

// File: verilog/ddp_pkg.sv
// Types shared by the DDR2 pin command and data interface.
// Assumes ddp_params.svh is on the include path.
`include "ddp_params.svh"

package ddp_pkg;

    // ************************************************************
    // Decoded commands
    // ************************************************************
    typedef enum logic [2:0] {
        DDP_CMD_MODE_SET  = `DDP_CODE_MODE_SET,
        DDP_CMD_REFRESH   = `DDP_CODE_REFRESH,
        DDP_CMD_PRECHARGE = `DDP_CODE_PRECHARGE,
        DDP_CMD_ACTIVE    = `DDP_CODE_ACTIVE,
        DDP_CMD_WRITE     = `DDP_CODE_WRITE,
        DDP_CMD_READ      = `DDP_CODE_READ,
        DDP_CMD_TERMINATE = `DDP_CODE_TERMINATE,
        DDP_CMD_NOP       = `DDP_CODE_NOP
    } ddp_cmd_e;

    // ************************************************************
    // Read drive states, one-hot
    // ************************************************************
    typedef enum logic [1:0] {
        DDP_RD_IDLE  = 2'b01,
        DDP_RD_DRIVE = 2'b10
    } ddp_rd_state_e;

endpackage

// File: verilog/ddp_core.sv
// Device side of a DDR2 pin command, address and data interface.
// Assumes all pins are asynchronous to clock_in and are sampled by it;
// the read data source sits on clock_in.
// What this block does
// - Commands carry and apply to the selected bank
// - Termination follows the sampled control input
// - Byte strobe driven by device on reads
// - Read strobe edge-aligned, write strobe centred
// - Lower strobe/mask bits 0-7, upper 8-15
// - Complement strobe used only in differential mode
// - Commands ignored while rank select high
// - Command decoded from three strobes plus rank
// - Masks sampled on both strobe edges
// - Masked write bytes captured with lane enable cleared
// - Control inputs sampled on rising clock crossing
// - Read data timed on both clock crossings
// - Clock enable gates command capture and sets the clocking flag
`timescale 1ns/1ps
`include "ddp_params.svh"

module ddp_core #(
    parameter int ADDR_W = 14,                          // Address pins
    parameter int BANK_W = 3                            // Bank select pins
) (
    input  wire logic              clock_in,            // System clock
    input  wire logic              rstn_in,             // Async reset, low
    input  wire logic              link_clk_in,         // True link clock pin
    input  wire logic              clock_enable_in,     // Clock enable pin
    input  wire logic              rank_select_n_in,    // Rank select, low
    input  wire logic              row_strobe_n_in,     // Row strobe, low
    input  wire logic              col_strobe_n_in,     // Column strobe, low
    input  wire logic              write_strobe_n_in,   // Write strobe, low
    input  wire logic [BANK_W-1:0] bank_select_lines_in, // Bank number
    input  wire logic [ADDR_W-1:0] address_in,          // Address pins
    input  wire logic              termination_control_in, // Termination
    input  wire logic [15:0]       data_lines_in,       // Data pins in
    output logic      [15:0]       data_lines_out,      // Data pins out
    output logic                   data_lines_oe_out,   // Data drive enable
    input  wire logic [1:0]        byte_strobe_in,      // Upper, lower strobe
    output logic      [1:0]        byte_strobe_out,     // Strobe out
    output logic                   byte_strobe_oe_out,  // Strobe enable
    input  wire logic [1:0]        byte_strobe_n_in,    // Complement in
    output logic      [1:0]        byte_strobe_n_out,   // Complement out
    output logic                   byte_strobe_n_oe_out, // Complement enable
    input  wire logic [1:0]        byte_mask_in,        // Upper, lower mask
    input  wire logic              rd_valid_in,         // Read word ready
    input  wire logic [15:0]       rd_data_in,          // Read word
    output logic                   cmd_valid_out,       // Command pulse
    output ddp_pkg::ddp_cmd_e      cmd_out,             // Decoded command
    output logic      [BANK_W-1:0] cmd_bank_out,        // Target bank
    output logic      [ADDR_W-1:0] cmd_addr_out,        // Command address
    output logic                   termination_on_out,  // Termination on
    output logic                   clocking_enabled_out, // Clocking active
    output logic                   diff_strobe_mode_out, // Differential mode
    output logic      [15:0]       wr_data_out,         // Captured write word
    output logic      [1:0]        wr_byte_en_out,      // Unmasked lanes
    output logic      [1:0]        wr_strobe_out        // Lane capture pulse
);
    import ddp_pkg::*;

    localparam int CTL_W = 6 + BANK_W + ADDR_W;         // Synced control bits
    localparam int DAT_W = 22;                          // Synced data bits

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [CTL_W-1:0] ctl_s1;                           // First stage
    logic [CTL_W-1:0] ctl_s2;                           // Second stage
    logic [DAT_W-1:0] dat_s1;                           // First stage
    logic [DAT_W-1:0] dat_s2;                           // Second stage
    logic             ck_s1;                            // Link clock stage 1
    logic             ck_s2;                            // Link clock stage 2
    logic             ck_s3;                            // Edge history
    logic [1:0]       dqs_s3;                           // Strobe history

    wire [CTL_W-1:0] ctl_raw = {clock_enable_in, rank_select_n_in,
                                row_strobe_n_in, col_strobe_n_in,
                                write_strobe_n_in, termination_control_in,
                                bank_select_lines_in, address_in};
    wire [DAT_W-1:0] dat_raw = {byte_strobe_in, byte_strobe_n_in,
                                byte_mask_in, data_lines_in};

    // Two flops on every pin before any logic
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctl_s1 <= '0;
            ctl_s2 <= '0;
            dat_s1 <= '0;
            dat_s2 <= '0;
            ck_s1  <= 1'b0;
            ck_s2  <= 1'b0;
            ck_s3  <= 1'b0;
            dqs_s3 <= `DDP_RST_LANES;
        end else begin
            ctl_s1 <= ctl_raw;
            ctl_s2 <= ctl_s1;
            dat_s1 <= dat_raw;
            dat_s2 <= dat_s1;
            ck_s1  <= link_clk_in;
            ck_s2  <= ck_s1;
            ck_s3  <= ck_s2;
            dqs_s3 <= dat_s2[21:20];
        end
    end

    // ************************************************************
    // Decoded views of the synced pins
    // ************************************************************
    wire              cke_s  = ctl_s2[CTL_W-1];         // Clock enable
    wire              cs_n_s = ctl_s2[CTL_W-2];         // Rank select
    wire [2:0]        code_s = ctl_s2[CTL_W-3:CTL_W-5]; // Command strobes
    wire              odt_s  = ctl_s2[CTL_W-6];         // Termination
    wire [BANK_W-1:0] bank_s = ctl_s2[ADDR_W+BANK_W-1:ADDR_W]; // Bank
    wire [ADDR_W-1:0] addr_s = ctl_s2[ADDR_W-1:0];      // Address
    wire [1:0]        dqs_s  = dat_s2[21:20];           // True strobes
    wire [1:0]        dqsn_s = dat_s2[19:18];           // Complement strobes
    wire [1:0]        mask_s = dat_s2[17:16];           // Byte masks
    wire [15:0]       dq_s   = dat_s2[15:0];            // Data lines

    wire ck_rise  = ck_s2 & ~ck_s3;
    wire ck_edge  = ck_s2 ^ ck_s3;
    wire cmd_take = ck_rise & cke_s & ~cs_n_s;
    wire cmd_real = cmd_take & (code_s != `DDP_CODE_NOP);
    wire emr_one  = cmd_real & (code_s == `DDP_CODE_MODE_SET)
                  & (bank_s == `DDP_EXT_MODE_ONE_BANK);

    // ************************************************************
    // Command capture on the rising crossing
    // ************************************************************
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cmd_valid_out        <= 1'b0;
            cmd_out              <= DDP_CMD_NOP;
            cmd_bank_out         <= `DDP_RST_CMD_BANK;
            cmd_addr_out         <= '0;
            termination_on_out   <= 1'b0;
            clocking_enabled_out <= 1'b0;
            diff_strobe_mode_out <= `DDP_RST_DIFF_MODE;
        end else begin
            cmd_valid_out <= cmd_real;
            if (cmd_real) begin
                cmd_out      <= ddp_cmd_e'(code_s);
                cmd_bank_out <= bank_s;
                cmd_addr_out <= addr_s;
            end
            if (ck_rise) begin
                termination_on_out   <= odt_s;
                clocking_enabled_out <= cke_s;
            end
            if (emr_one) begin
                diff_strobe_mode_out <= addr_s[`DDP_DIFF_STROBE_BIT];
            end
        end
    end

    // ************************************************************
    // Read drive: data and strobe on both crossings
    // ************************************************************
    ddp_rd_state_e rd_state;                            // Drive state
    ddp_rd_state_e next_rd_state;                       // Next drive state

    always_comb begin
        next_rd_state = rd_state;
        case (rd_state)
            DDP_RD_IDLE: begin
                if (ck_edge && rd_valid_in) begin
                    next_rd_state = DDP_RD_DRIVE;
                end
            end
            DDP_RD_DRIVE: begin
                if (ck_edge && !rd_valid_in) begin
                    next_rd_state = DDP_RD_IDLE;
                end
            end
            default: begin
                next_rd_state = DDP_RD_IDLE;
            end
        endcase
    end

    wire       rd_beat    = ck_edge & rd_valid_in;
    wire       next_oe    = (next_rd_state == DDP_RD_DRIVE);
    wire [1:0] next_dqs   = rd_beat ? ~byte_strobe_out
                          : (next_oe ? byte_strobe_out : `DDP_RST_LANES);

    // Strobe toggles with each new word, so it is edge-aligned
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rd_state             <= DDP_RD_IDLE;
            data_lines_out       <= `DDP_RST_WORD;
            data_lines_oe_out    <= 1'b0;
            byte_strobe_out      <= `DDP_RST_LANES;
            byte_strobe_oe_out   <= 1'b0;
            byte_strobe_n_out    <= ~`DDP_RST_LANES;
            byte_strobe_n_oe_out <= 1'b0;
        end else begin
            rd_state             <= next_rd_state;
            if (rd_beat) begin
                data_lines_out <= rd_data_in;
            end
            data_lines_oe_out    <= next_oe;
            byte_strobe_out      <= next_dqs;
            byte_strobe_oe_out   <= next_oe;
            byte_strobe_n_out    <= ~next_dqs;
            byte_strobe_n_oe_out <= next_oe & diff_strobe_mode_out;
        end
    end

    // ************************************************************
    // Write capture, one lane per byte
    // ************************************************************
    genvar ln;
    generate
        for (ln = 0; ln < 2; ln++) begin : g_lane
            // Complement only qualifies the edge in differential mode
            wire pair_ok  = !diff_strobe_mode_out || (dqs_s[ln] != dqsn_s[ln]);
            wire dqs_edge = (dqs_s[ln] ^ dqs_s3[ln]) & pair_ok
                          & ~data_lines_oe_out;

            // Byte and mask taken together on either strobe edge
            always_ff @(posedge clock_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    wr_data_out[ln*8 +: 8] <= 8'h00;
                    wr_byte_en_out[ln]     <= 1'b0;
                    wr_strobe_out[ln]      <= 1'b0;
                end else begin
                    wr_strobe_out[ln] <= dqs_edge;
                    if (dqs_edge) begin
                        wr_data_out[ln*8 +: 8] <= dq_s[ln*8 +: 8];
                        wr_byte_en_out[ln]     <= ~mask_s[ln];
                    end
                end
            end
        end
    endgenerate

    // ************************************************************
    // Assertions and cover points
    // ************************************************************
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rstn_in);

    a_rank_mask_ignore: assert property (ck_rise && cs_n_s |=> !cmd_valid_out)
        else $error("command taken while rank select high");
    a_cmd_decode_act: assert property (cmd_take && code_s == `DDP_CODE_ACTIVE
        |=> cmd_valid_out && cmd_out == DDP_CMD_ACTIVE)
        else $error("active command not decoded");
    a_bank_follow: assert property (cmd_real |=> cmd_bank_out == $past(bank_s))
        else $error("command bank does not match pins");
    a_term_follow: assert property (ck_rise |=> termination_on_out == $past(odt_s))
        else $error("termination does not follow sampled input");
    // Gated rise: clocking drops and no command shows in the very next cycle
    a_clock_gate: assert property (ck_rise && !cke_s
        |=> !clocking_enabled_out && !cmd_valid_out)
        else $error("clocking or command while clock enable low");
    a_diff_mode_set: assert property (emr_one
        |=> diff_strobe_mode_out == $past(addr_s[`DDP_DIFF_STROBE_BIT]))
        else $error("differential mode bit not taken");
    a_comp_strobe_off: assert property (!$past(diff_strobe_mode_out)
        |-> !byte_strobe_n_oe_out)
        else $error("complement strobe driven in single-ended mode");
    a_mask_drop_low: assert property (wr_strobe_out[0]
        |-> wr_byte_en_out[0] == !$past(mask_s[0])
        && wr_data_out[7:0] == $past(dq_s[7:0]))
        else $error("lower lane mask or data wrong");
    a_mask_drop_up: assert property (wr_strobe_out[1]
        |-> wr_byte_en_out[1] == !$past(mask_s[1])
        && wr_data_out[15:8] == $past(dq_s[15:8]))
        else $error("upper lane mask or data wrong");
    a_read_beat: assert property (rd_beat
        |=> data_lines_oe_out && byte_strobe_oe_out
        && data_lines_out == $past(rd_data_in))
        else $error("read word not driven on clock crossing");
    a_read_strobe_edge: assert property (rd_beat
        |=> byte_strobe_out != $past(byte_strobe_out))
        else $error("read strobe not toggled with data");

    c_read_burst: cover property (rd_beat ##[1:20] rd_beat);
    c_masked_write: cover property (wr_strobe_out[0] && !wr_byte_en_out[0]);
    c_diff_enable: cover property (emr_one && addr_s[`DDP_DIFF_STROBE_BIT]);
    c_rank_ignored: cover property (ck_rise && cke_s && cs_n_s
        && code_s == `DDP_CODE_ACTIVE);

endmodule

// File: verif/ddp_ctrl_model.sv
// Controller-side pin model: link clock, write data, masks and strobes.
// Assumes the bench calls its tasks from the clock_in domain.
`timescale 1ns/1ps

module ddp_ctrl_model (
    input  wire logic        clock_in,        // System clock
    input  wire logic [15:0] dev_data_in,     // Device read data
    input  wire logic        dev_data_oe_in,  // Device drives data
    input  wire logic [1:0]  dev_strobe_in,   // Device true strobes
    input  wire logic        dev_strobe_oe_in, // Device drives strobes
    input  wire logic [1:0]  dev_strobe_n_in, // Device complement strobes
    input  wire logic        dev_strobe_n_oe_in, // Device drives complements
    output logic             link_clk_out,    // Free-running link clock
    output logic      [15:0] data_lines_out,  // Resolved data pins
    output logic      [1:0]  byte_strobe_out, // Resolved true strobes
    output logic      [1:0]  byte_strobe_n_out, // Resolved complements
    output logic      [1:0]  byte_mask_out    // Write masks
);
    // ************************************************************
    // Pin state held by the controller
    // ************************************************************
    logic [15:0] wdata   = 16'h0000;         // Write word
    logic [1:0]  wmask   = 2'h0;             // Write masks
    logic [1:0]  wstrobe = 2'h0;             // Write strobes
    logic [1:0]  nflip   = 2'h3;             // 3 gives a true complement
    logic        wdrv    = 1'b0;             // Controller drives data

    // Link clock runs free, phase unrelated to clock_in
    initial begin
        link_clk_out = 1'b0;
        #137;
        forever #400 link_clk_out = ~link_clk_out;
    end

    // Released lines show the inverse of the last value
    assign data_lines_out = dev_data_oe_in ? dev_data_in : (wdrv ? wdata : ~wdata);
    assign byte_mask_out = wdrv ? wmask : ~wmask;
    assign byte_strobe_out = dev_strobe_oe_in ? dev_strobe_in : wstrobe;
    assign byte_strobe_n_out = dev_strobe_n_oe_in ? dev_strobe_n_in : wstrobe ^ nflip;

    // One strobe edge three cycles after the data window opens
    task automatic strobe_edge(input logic lane, input logic [15:0] d,
                               input logic [1:0] m, input logic bad);
        @(posedge clock_in) #10;
        wdata = d;
        wmask = m;
        wdrv = 1'b1;
        nflip = bad ? 2'h0 : 2'h3;
        repeat (3) @(posedge clock_in);
        #10 wstrobe[lane] = ~wstrobe[lane];
    endtask

    // Hold the window after the last edge, then let go
    task automatic release_bus;
        repeat (3) @(posedge clock_in);
        #10 wdrv = 1'b0;
        nflip = 2'h3;
    endtask
endmodule

// File: verif/tb_ddp_core.sv
// Self-checking bench for the DDR2 pin command and data interface.
// Assumes ddp_pkg and ddp_core are compiled first.
`timescale 1ns/1ps

module tb_ddp_core;
    import ddp_pkg::*;
    // ************************************************************
    // Stimulus and observed signals
    // ************************************************************
    logic        clock_in               = 1'b0;     // System clock
    logic        rstn_in                = 1'b0;     // Reset, low active
    logic        clock_enable_in        = 1'b1;     // Clock enable pin
    logic        rank_select_n_in       = 1'b1;     // Rank select pin
    logic [2:0]  cmd_pins               = 3'h7;     // Row, column, write
    logic [2:0]  bank_select_lines_in   = 3'h0;     // Bank number
    logic [13:0] address_in             = 14'h0000; // Address pins
    logic        termination_control_in = 1'b0;     // Termination pin
    logic        rd_valid_in            = 1'b0;     // Read word ready
    logic [15:0] rd_data_in             = 16'h0000; // Read word
    logic        diff_exp               = 1'b0;     // Expected strobe mode
    int          n_fail                 = 0;        // Mismatch count
    int          compares               = 0;        // Comparison count
    logic        link_clk, data_oe, strobe_oe, strobe_n_oe, cmd_valid;
    logic        term_on, clk_en_out, diff_mode;
    logic [15:0] data_in, data_out, wr_data;
    logic [1:0]  strobe_in, strobe_out, strobe_n_in, strobe_n_out, mask;
    logic [1:0]  wr_byte_en, wr_strobe;
    logic [2:0]  cmd_bank;
    logic [13:0] cmd_addr;
    ddp_cmd_e    cmd;

    always #50 clock_in = ~clock_in;

    ddp_core dut_u (.clock_in(clock_in), .rstn_in(rstn_in), .link_clk_in(link_clk),
        .clock_enable_in(clock_enable_in), .rank_select_n_in(rank_select_n_in),
        .row_strobe_n_in(cmd_pins[2]), .col_strobe_n_in(cmd_pins[1]),
        .write_strobe_n_in(cmd_pins[0]), .bank_select_lines_in(bank_select_lines_in),
        .address_in(address_in), .termination_control_in(termination_control_in),
        .data_lines_in(data_in), .data_lines_out(data_out), .data_lines_oe_out(data_oe),
        .byte_strobe_in(strobe_in), .byte_strobe_out(strobe_out),
        .byte_strobe_oe_out(strobe_oe), .byte_strobe_n_in(strobe_n_in),
        .byte_strobe_n_out(strobe_n_out), .byte_strobe_n_oe_out(strobe_n_oe),
        .byte_mask_in(mask), .rd_valid_in(rd_valid_in), .rd_data_in(rd_data_in),
        .cmd_valid_out(cmd_valid), .cmd_out(cmd), .cmd_bank_out(cmd_bank),
        .cmd_addr_out(cmd_addr), .termination_on_out(term_on),
        .clocking_enabled_out(clk_en_out), .diff_strobe_mode_out(diff_mode),
        .wr_data_out(wr_data), .wr_byte_en_out(wr_byte_en), .wr_strobe_out(wr_strobe));

    ddp_ctrl_model ctrl_u (.clock_in(clock_in), .dev_data_in(data_out),
        .dev_data_oe_in(data_oe), .dev_strobe_in(strobe_out), .dev_strobe_oe_in(strobe_oe),
        .dev_strobe_n_in(strobe_n_out), .dev_strobe_n_oe_in(strobe_n_oe),
        .link_clk_out(link_clk), .data_lines_out(data_in), .byte_strobe_out(strobe_in),
        .byte_strobe_n_out(strobe_n_in), .byte_mask_out(mask));

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic complete_run;
        if (n_fail == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Bounded wait: 0 command, 1 strobe change, 2 data released, 3 write pulse
    task automatic wait_for(input int sel, input bit must, output bit hit);
        logic [1:0] prev;
        prev = strobe_out;
        hit = 1'b0;
        for (int i = 0; i < 12 && !hit; i++) begin
            @(posedge clock_in) #10;
            case (sel)
                0: hit = (cmd_valid === 1'b1);
                1: hit = (strobe_out !== prev);
                2: hit = (data_oe === 1'b0);
                default: hit = (wr_strobe !== 2'h0);
            endcase
        end
        if (must && !hit) begin
            n_fail++;
            complete_run();
        end
    endtask

    // Bounded wait for the link clock to leave lvl and come back to it
    task automatic wait_link(input logic lvl);
        int phase;
        phase = 0;
        for (int i = 0; i < 24 && phase < 2; i++) begin
            @(posedge clock_in) #10;
            if (phase == 0 && link_clk !== lvl) begin
                phase = 1;
            end else if (phase == 1 && link_clk === lvl) begin
                phase = 2;
            end
        end
        if (phase < 2) begin
            n_fail++;
            complete_run();
        end
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic reset_run;
        repeat (4) @(posedge clock_in);
        #10 rstn_in = 1'b1;
        check("rst_cmd", 16'(cmd), 16'h0007);
        check("rst_pins", 16'({strobe_n_out, data_oe, strobe_oe, cmd_valid}), 16'h0018);
        repeat (3) @(posedge clock_in);
    endtask

    task automatic diff_mode_check(input logic exp_on);
        diff_exp = exp_on;
        check("diff_mode", 16'(diff_mode), {15'h0, exp_on});
    endtask

    task automatic send_cmd(input logic ce, input logic cs_n, input logic [2:0] code,
                            input logic [2:0] bank, input logic [13:0] addr, input logic termination_control);
        bit hit;
        wait_link(1'b0);
        clock_enable_in = ce;
        rank_select_n_in = cs_n;
        cmd_pins = code;
        bank_select_lines_in = bank;
        address_in = addr;
        termination_control_in = termination_control;
        wait_link(1'b1);
        wait_for(0, 1'b0, hit);
        check("cmd_valid", 16'(hit), 16'(!cs_n && ce && code != 3'h7));
        if (hit) begin
            check("cmd_code", 16'(cmd), 16'(code));
            check("cmd_bank", 16'(cmd_bank), 16'(bank));
            check("cmd_addr", 16'(cmd_addr), 16'(addr));
        end
        check("termination", 16'(term_on), 16'(termination_control));
        check("clocking", 16'(clk_en_out), 16'(ce));
        cmd_pins = 3'h7;
    endtask

    task automatic read_burst;
        bit hit;
        wait_link(1'b1);
        rd_valid_in = 1'b1;
        rd_data_in = 16'hC301;
        for (int i = 0; i < 4; i++) begin
            wait_for(1, 1'b1, hit);
            check("read_data", data_out, 16'hC301 + 16'(i) * 16'h1111);
            check("read_strobe", 16'(strobe_out), 16'(i[0] ? 2'h0 : 2'h3));
            check("strobe_en", 16'({data_oe, strobe_oe, strobe_n_oe}),
                  {13'h0, 2'h3, diff_exp});
            check("strobe_cmpl", 16'(strobe_n_out), {14'h0, ~strobe_out});
            rd_data_in = 16'hC301 + 16'(i + 1) * 16'h1111;
        end
        rd_valid_in = 1'b0;
        wait_for(2, 1'b1, hit);
        check("strobe_idle", 16'({strobe_oe, strobe_out}), 16'h0000);
    endtask

    task automatic write_beat(input logic lane, input logic [15:0] d, input logic [1:0] m,
                              input logic bad);
        bit hit;
        logic take;
        take = !(bad && diff_exp);
        ctrl_u.strobe_edge(lane, d, m, bad);
        wait_for(3, 1'b0, hit);
        check("wr_pulse", 16'(wr_strobe), {14'h0, take & lane, take & ~lane});
        if (take) begin
            check("wr_keep", 16'(wr_byte_en[lane]), {15'h0, ~m[lane]});
            if (!m[lane]) check("wr_byte", {8'h0, lane ? wr_data[15:8] : wr_data[7:0]},
                                {8'h0, lane ? d[15:8] : d[7:0]});
        end
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        reset_run();
        for (int i = 0; i < 7; i++) begin
            send_cmd(1'b1, 1'b0, 3'(i), 3'(7 - i), 14'h1A5C ^ 14'(i), i[0]);
        end
        send_cmd(1'b1, 1'b1, 3'h3, 3'h2, 14'h0100, 1'b1);
        send_cmd(1'b0, 1'b0, 3'h5, 3'h4, 14'h0200, 1'b0);
        send_cmd(1'b1, 1'b0, 3'h7, 3'h1, 14'h0300, 1'b1);
        send_cmd(1'b1, 1'b0, 3'h0, 3'h1, 14'h0400, 1'b0);
        diff_mode_check(1'b1);
        read_burst();
        write_beat(1'b0, 16'h3CA5, 2'h0, 1'b1);
        write_beat(1'b0, 16'h3CA5, 2'h0, 1'b1);
        write_beat(1'b0, 16'h5A0F, 2'h0, 1'b0);
        write_beat(1'b1, 16'h96E1, 2'h2, 1'b0);
        write_beat(1'b1, 16'h7B48, 2'h1, 1'b0);
        write_beat(1'b0, 16'hE2D3, 2'h1, 1'b0);
        ctrl_u.release_bus();
        send_cmd(1'b1, 1'b0, 3'h0, 3'h1, 14'h0000, 1'b1);
        send_cmd(1'b1, 1'b0, 3'h0, 3'h2, 14'h0400, 1'b0);
        diff_mode_check(1'b0);
        read_burst();
        write_beat(1'b1, 16'h4D2C, 2'h0, 1'b1);
        write_beat(1'b1, 16'hB1F0, 2'h0, 1'b1);
        ctrl_u.release_bus();
        complete_run();
    end
endmodule
